// *** pkg/fpio_pkg.sv ***
// Shared constants, register map and carrier types of the five-port I/O
package fpio_pkg;

  // Port geometry
  localparam int NPORT = 5;
  localparam int PW = 8;
  localparam int NIRQ = 5;
  localparam int ADDR_W = 12;
  localparam int IDX_W = 10;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_SFR_IE = 10'h000;
  localparam logic [IDX_W-1:0] IDX_SFR_IFG = 10'h002;
  localparam logic [IDX_W-1:0] PORT_BASE [NPORT] =
    '{10'h010, 10'h020, 10'h028, 10'h018, 10'h01C};

  // Lowest field bit of the two port-zero pins inside the SPECIAL_FUNCTION_AREA words
  localparam int SFR_P0_LSB = 2;
  // Port-zero pins whose flag and enable live in the SPECIAL_FUNCTION_AREA words
  localparam logic [PW-1:0] SFR_PIN_MASK = 8'h03;

  // Offsets inside a port group
  localparam logic [IDX_W-1:0] OFF_IN = 10'h000;
  localparam logic [IDX_W-1:0] OFF_OUT = 10'h001;
  localparam logic [IDX_W-1:0] OFF_DIR = 10'h002;
  localparam logic [IDX_W-1:0] OFF_IFG = 10'h003;
  localparam logic [IDX_W-1:0] OFF_IES = 10'h004;
  localparam logic [IDX_W-1:0] OFF_IE = 10'h005;
  localparam logic [IDX_W-1:0] OFF_SEL = 10'h006;
  localparam logic [IDX_W-1:0] OFF_SEL_SMALL = 10'h003;

  // Register counts of the three port flavours
  localparam logic [IDX_W-1:0] NREG_P0 = 10'h006;
  localparam logic [IDX_W-1:0] NREG_IRQ = 10'h007;
  localparam logic [IDX_W-1:0] NREG_PLAIN = 10'h004;

  // Reset value of every control bit
  localparam logic [PW-1:0] RST_BYTE = 8'h00;
  localparam logic [PW-1:0] ALL_ONES = 8'hFF;

  // Which register a write lands in
  typedef enum logic [2:0] {
    RK_NONE = 3'h0,
    RK_OUT = 3'h1,
    RK_DIR = 3'h2,
    RK_IES = 3'h3,
    RK_IFG = 3'h4,
    RK_IE = 3'h5,
    RK_SEL = 3'h6
  } fpio_reg_e;

  // Control state of one port
  typedef struct packed {
    logic [PW-1:0] sel;
    logic [PW-1:0] ie;
    logic [PW-1:0] ifg;
    logic [PW-1:0] ies;
    logic [PW-1:0] dir;
    logic [PW-1:0] out;
  } fpio_cfg_t;

  // One masked register write toward a port
  typedef struct packed {
    logic en;
    fpio_reg_e kind;
    logic [PW-1:0] mask;
    logic [PW-1:0] data;
  } fpio_wr_t;

endpackage

// *** design/fpio_sync.sv ***
// Two-flop synchroniser for pad levels
`timescale 1ns/1ps
`default_nettype none
module fpio_sync #(
  parameter int W = 8
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [W-1:0] asyncIn,
  output logic [W-1:0] syncOut
);
  // First stage, read only by the second
  logic [W-1:0] meta_reg;

  // Both stages clear on reset
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg <= '0;
      syncOut <= '0;
    end else begin
      meta_reg <= asyncIn;
      syncOut <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// *** design/fpio_port.sv ***
// One eight-pin port: control registers, edge detect and flags
`timescale 1ns/1ps
`default_nettype none
module fpio_port #(
  parameter bit HAS_IRQ = 1'b1
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [fpio_pkg::PW-1:0] level,
  input wire fpio_pkg::fpio_wr_t wr,
  output fpio_pkg::fpio_cfg_t cfg
);
  import fpio_pkg::*;

  // Previous level, for edge detection
  logic [PW-1:0] levelDly_reg;
  // Set once a real previous level exists; avoids a false edge at reset
  logic primed_reg;
  logic [PW-1:0] rise;
  logic [PW-1:0] fall;
  logic [PW-1:0] edgeHit;
  // Interrupt fields exist only on interrupt-capable ports
  logic [PW-1:0] irqKeep;
  fpio_cfg_t cfg_next;

  assign irqKeep = HAS_IRQ ? ALL_ONES : RST_BYTE;
  assign rise = level & ~levelDly_reg;
  assign fall = ~level & levelDly_reg;
  // Edge select: zero picks rising, one picks falling
  assign edgeHit = ((rise & ~cfg.ies) | (fall & cfg.ies))
    & {PW{primed_reg}} & irqKeep;

  // Masked merge of a write into one field
  function automatic logic [PW-1:0] merge(
    input logic [PW-1:0] old,
    input logic hitKind
  );
    merge = hitKind ? ((old & ~wr.mask) | (wr.data & wr.mask)) : old;
  endfunction

  // Each bit written on its own through the mask
  always_comb begin
    cfg_next.out = merge(cfg.out, wr.en && wr.kind == RK_OUT);
    cfg_next.dir = merge(cfg.dir, wr.en && wr.kind == RK_DIR);
    cfg_next.sel = merge(cfg.sel, wr.en && wr.kind == RK_SEL);
    cfg_next.ies = merge(cfg.ies, wr.en && wr.kind == RK_IES)
      & irqKeep;
    cfg_next.ie = merge(cfg.ie, wr.en && wr.kind == RK_IE)
      & irqKeep;
    // New edge wins over a clear in the same cycle
    cfg_next.ifg = (merge(cfg.ifg, wr.en && wr.kind == RK_IFG)
      | edgeHit) & irqKeep;
  end

  // Register update
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg <= '0;
      levelDly_reg <= RST_BYTE;
      primed_reg <= 1'b0;
    end else begin
      cfg <= cfg_next;
      levelDly_reg <= level;
      primed_reg <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// *** design/fpio_top.sv ***
// Five-port digital I/O block with APB register access
//
// Contract
// - Five ports zero to four, eight pins
// - Register counts six, seven, seven, four, four
// - Every pin configured independently of others
// - Ports zero to two have pin interrupts
// - Input register reads present pin levels
// - Output register drives pins set as outputs
// - Direction bit picks input or output
// - Edge select picks rising or falling event
// - Flag bit shows pending pin event
// - Enable bit gates flag into request
// - Function select hands pin to peripheral
// - Eight-bit registers; port-zero flag/enable six bits
// - Port-zero pins 0,1 flag/enable in SPECIAL_FUNCTION_AREA
// - Five vectors: p0.0, p0.1, p0.2-7, p1, p2
// - Every register readable; all but the input register writable
`timescale 1ns/1ps
`default_nettype none
module fpio_top (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [fpio_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [fpio_pkg::NPORT-1:0][fpio_pkg::PW-1:0] padIn,
  output logic [fpio_pkg::NPORT-1:0][fpio_pkg::PW-1:0] padOut,
  output logic [fpio_pkg::NPORT-1:0][fpio_pkg::PW-1:0] padOe,
  input wire logic [fpio_pkg::NPORT-1:0][fpio_pkg::PW-1:0] periphOut,
  input wire logic [fpio_pkg::NPORT-1:0][fpio_pkg::PW-1:0] periphOe,
  output logic [fpio_pkg::NPORT-1:0][fpio_pkg::PW-1:0] periphIn,
  output logic [fpio_pkg::NIRQ-1:0] portIrq
);
  import fpio_pkg::*;

  // Synchronised pin levels
  logic [NPORT-1:0][PW-1:0] level;
  // Control state of every port
  fpio_cfg_t cfg [NPORT];
  // Write request per port
  fpio_wr_t wrBus [NPORT];

  // Register index taken from the word address
  logic [IDX_W-1:0] idx;
  // Decode results
  logic hit;
  logic [2:0] decPort;
  fpio_reg_e decKind;
  logic [PW-1:0] decMask;
  logic [PW-1:0] decData;
  logic [31:0] rdNext;

  // Bus phases
  logic setupPhase;
  logic doWrite;

  // Output next values
  logic [NPORT-1:0][PW-1:0] padOut_next;
  logic [NPORT-1:0][PW-1:0] padOe_next;
  logic [NIRQ-1:0] irq_next;

  assign idx = paddr[ADDR_W-1:2];
  assign setupPhase = psel & ~penable;
  // Write commits only at the access edge that also sees pready
  assign doWrite = psel & penable & pready & pwrite & hit;

  // Pad synchronisers, one per port
  genvar gp;
  generate
    for (gp = 0; gp < NPORT; gp++) begin : g_port
      fpio_sync #(
        .W(PW)
      ) u_sync (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .asyncIn(padIn[gp]),
        .syncOut(level[gp])
      );

      // Port three and four lack interrupt logic
      fpio_port #(
        .HAS_IRQ(gp < 3)
      ) u_port (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .level(level[gp]),
        .wr(wrBus[gp]),
        .cfg(cfg[gp])
      );

      // Route the decoded write to its port only
      assign wrBus[gp] = '{
        en: doWrite && decPort == 3'(gp),
        kind: decKind,
        mask: decMask,
        data: decData
      };

      // Peripheral takes the pin when selected
      assign padOut_next[gp] = (cfg[gp].sel & periphOut[gp])
        | (~cfg[gp].sel & cfg[gp].out);
      assign padOe_next[gp] = (cfg[gp].sel & periphOe[gp])
        | (~cfg[gp].sel & cfg[gp].dir);
    end
  endgenerate

  // Five request lines from flag and enable
  assign irq_next[0] = cfg[0].ifg[0] & cfg[0].ie[0];
  assign irq_next[1] = cfg[0].ifg[1] & cfg[0].ie[1];
  assign irq_next[2] = |(cfg[0].ifg & cfg[0].ie & ~SFR_PIN_MASK);
  assign irq_next[3] = |(cfg[1].ifg & cfg[1].ie);
  assign irq_next[4] = |(cfg[2].ifg & cfg[2].ie);

  // Address decode, read mux and write steering
  always_comb begin
    logic [IDX_W-1:0] off;
    logic [IDX_W-1:0] nReg;
    logic [PW-1:0] rdByte;
    off = '0;
    nReg = '0;
    rdByte = RST_BYTE;
    hit = 1'b0;
    decPort = 3'h0;
    decKind = RK_NONE;
    decMask = ALL_ONES;
    decData = pwdata[PW-1:0];
    rdNext = 32'h0000_0000;
    // Port-zero low pins live in the SPECIAL_FUNCTION_AREA words
    if (idx == IDX_SFR_IE) begin
      hit = 1'b1;
      decKind = RK_IE;
      decMask = SFR_PIN_MASK;
      decData = {6'h00, pwdata[SFR_P0_LSB+1:SFR_P0_LSB]};
      rdNext[SFR_P0_LSB+1:SFR_P0_LSB] = cfg[0].ie[1:0];
    end else if (idx == IDX_SFR_IFG) begin
      hit = 1'b1;
      decKind = RK_IFG;
      decMask = SFR_PIN_MASK;
      decData = {6'h00, pwdata[SFR_P0_LSB+1:SFR_P0_LSB]};
      rdNext[SFR_P0_LSB+1:SFR_P0_LSB] = cfg[0].ifg[1:0];
    end else begin
      for (int p = 0; p < NPORT; p++) begin
        // Register count depends on port flavour
        if (p == 0) begin
          nReg = NREG_P0;
        end else if (p < 3) begin
          nReg = NREG_IRQ;
        end else begin
          nReg = NREG_PLAIN;
        end
        off = idx - PORT_BASE[p];
        if (idx >= PORT_BASE[p] && off < nReg) begin
          hit = 1'b1;
          decPort = 3'(p);
          // Port zero keeps only the upper six flag and enable bits
          if (p == 0) begin
            decMask = ~SFR_PIN_MASK;
          end
          if (off == OFF_IN) begin
            rdByte = level[p];
          end else if (off == OFF_OUT) begin
            decKind = RK_OUT;
            rdByte = cfg[p].out;
          end else if (off == OFF_DIR) begin
            decKind = RK_DIR;
            rdByte = cfg[p].dir;
          end else if (p >= 3 && off == OFF_SEL_SMALL) begin
            decKind = RK_SEL;
            rdByte = cfg[p].sel;
          end else if (off == OFF_IFG) begin
            decKind = RK_IFG;
            rdByte = cfg[p].ifg & decMask;
          end else if (off == OFF_IES) begin
            decKind = RK_IES;
            rdByte = cfg[p].ies;
          end else if (off == OFF_IE) begin
            decKind = RK_IE;
            rdByte = cfg[p].ie & decMask;
          end else if (off == OFF_SEL) begin
            decKind = RK_SEL;
            rdByte = cfg[p].sel;
          end
          // Input register ignores writes; all else is writable
          if (p != 0 || (off != OFF_IFG && off != OFF_IE)) begin
            decMask = ALL_ONES;
          end
          rdNext[PW-1:0] = rdByte;
        end
      end
    end
  end

  // Bus answer: zero wait state, data caught during setup
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setupPhase;
      // Unmapped index answers with an error
      pslverr <= setupPhase & ~hit;
      if (setupPhase) begin
        prdata <= pwrite ? 32'h0000_0000 : rdNext;
      end
    end
  end

  // Pad drive and request lines from flip-flops
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      padOut <= '0;
      padOe <= '0;
      periphIn <= '0;
      portIrq <= '0;
    end else begin
      padOut <= padOut_next;
      padOe <= padOe_next;
      periphIn <= level;
      portIrq <= irq_next;
    end
  end
endmodule
`default_nettype wire

// *** tb/fpio_top_asserts.sv ***
// Port-level assertions of the five-port I/O block
`timescale 1ns/1ps
`default_nettype none
module fpio_top_asserts (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [fpio_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [fpio_pkg::NPORT-1:0][fpio_pkg::PW-1:0] padIn,
  input wire logic [fpio_pkg::NPORT-1:0][fpio_pkg::PW-1:0] padOe,
  input wire logic [fpio_pkg::NPORT-1:0][fpio_pkg::PW-1:0] periphIn
);
  import fpio_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // Cycles since reset, saturating; sync flops need time to fill
  logic [1:0] upCnt;
  // Write commit seen on the bus
  wire commitWr = psel && penable && pready && pwrite;
  // Count the first edges after release
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      upCnt <= 2'h0;
    end else if (upCnt != 2'h3) begin
      upCnt <= upCnt + 2'h1;
    end
  end
  // Setup phase of a transfer
  sequence s_setup;
    psel && !penable;
  endsequence
  // Read setup toward an index past the map
  sequence s_bad_read;
    s_setup ##0 !pwrite && paddr[ADDR_W-1:2] > 10'h02F;
  endsequence
  a_ready_next: assert property (s_setup |=> pready)
    else $error("no ready after setup");
  a_ready_cause: assert property (pready |->
    psel && penable && $past(psel && !penable))
    else $error("ready outside an access phase");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_unmapped_err: assert property (s_bad_read |=>
    pslverr && prdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  a_mapped_ok: assert property (s_setup ##0
    paddr[ADDR_W-1:2] inside {[10'h020:10'h026]} |=> !pslverr)
    else $error("mapped register refused");
  a_upper_zero: assert property (pready && !pwrite |->
    prdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  a_oe_cause: assert property ($changed(padOe) |->
    $past(commitWr) || $past(commitWr, 2))
    else $error("pin enable moved without a write");
  // Pin to periphIn is two sync flops plus the output flop: three edges
  a_sync_pins: assert property (upCnt == 2'h3 && padIn == $past(padIn)
    && padIn == $past(padIn, 2) && padIn == $past(padIn, 3)
    |-> periphIn == padIn)
    else $error("peripheral input not following pins");
endmodule
`default_nettype wire

// *** tb/fpio_pin_model.sv ***
// External pin model: board drive where the block does not drive
`timescale 1ns/1ps
`default_nettype none
module fpio_pin_model (
  input wire logic [fpio_pkg::NPORT-1:0][fpio_pkg::PW-1:0] padOut,
  input wire logic [fpio_pkg::NPORT-1:0][fpio_pkg::PW-1:0] padOe,
  input wire logic [fpio_pkg::NPORT-1:0][fpio_pkg::PW-1:0] extLevel,
  output logic [fpio_pkg::NPORT-1:0][fpio_pkg::PW-1:0] padIn
);
  import fpio_pkg::*;
  // Driven pins show the block's value, others the board's level
  assign padIn = (padOut & padOe) | (extLevel & ~padOe);
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench of the five-port I/O block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import fpio_pkg::*;
  logic sys_clk, arst_n, psel, penable, pwrite, pready, pslverr, erv;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [NPORT-1:0][PW-1:0] padIn, padOut, padOe, periphIn, extLevel;
  logic [NPORT-1:0][PW-1:0] periphOut, periphOe;
  logic [NIRQ-1:0] portIrq;
  int errTotal, checksDone;
  // Vector table: port, pin, bit in flag word, enable and flag index
  int vPort [5] = '{0, 0, 0, 1, 2};
  int vPin [5] = '{0, 1, 5, 3, 7};
  int vBit [5] = '{2, 3, 5, 3, 7};
  logic [IDX_W-1:0] vIe [5] = '{10'h000, 10'h000, 10'h015, 10'h025, 10'h02D};
  logic [IDX_W-1:0] vIfg [5] = '{10'h002, 10'h002, 10'h013, 10'h023, 10'h02B};
  // Holes in the map, gaps between groups included
  logic [IDX_W-1:0] bad [3] = '{10'h016, 10'h027, 10'h3FF};
  fpio_top i_dut (.sys_clk(sys_clk), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .padIn(padIn),
    .padOut(padOut), .padOe(padOe), .periphOut(periphOut),
    .periphOe(periphOe), .periphIn(periphIn), .portIrq(portIrq));
  fpio_pin_model i_pins (.padOut(padOut), .padOe(padOe),
    .extLevel(extLevel), .padIn(padIn));
  // 100 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Verdict and end of run
  task automatic wrapUp;
    $display("checks %0d mismatches %0d", checksDone, errTotal);
    if (errTotal == 0 && checksDone > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // One comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      errTotal++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; request held until ready is sampled high
  task automatic xfer(input logic wr, input logic [IDX_W-1:0] idx,
    input logic [PW-1:0] wd);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h00_0000, wd};
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // A stuck slave counts against the run
    if (n >= 20) begin
      errTotal++;
      $display("mismatch at %0t: no ready from slave", $time);
    end
  endtask
  task automatic wr(input logic [IDX_W-1:0] idx, input logic [PW-1:0] d);
    xfer(1'b1, idx, d);
  endtask
  task automatic rd(input logic [IDX_W-1:0] idx, input logic [PW-1:0] e);
    xfer(1'b0, idx, 8'h00);
    chk(rdv, {24'h00_0000, e});
  endtask
  // Main sequence
  initial begin
    logic [IDX_W-1:0] b, s;
    logic [PW-1:0] pat, m;
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    extLevel = '0;
    periphOut = {NPORT{8'h99}};
    periphOe = {NPORT{8'h5A}};
    repeat (8) @(posedge sys_clk);
    arst_n <= 1'b1;
    extLevel <= {NPORT{8'h0F}};
    // Data and direction on every group, function select on groups one to four
    for (int p = 0; p < NPORT; p++) begin
      b = PORT_BASE[p];
      s = (p > 2) ? OFF_SEL_SMALL : OFF_SEL;
      pat = 8'hA5 ^ 8'(p);
      rd(b + OFF_DIR, RST_BYTE);
      wr(b + OFF_OUT, pat);
      wr(b + OFF_DIR, 8'h3C);
      rd(b + OFF_OUT, pat);
      rd(b + OFF_DIR, 8'h3C);
      chk(padOe[p], 8'h3C);
      chk(padOut[p] & 8'h3C, pat & 8'h3C);
      rd(b + OFF_IN, (pat & 8'h3C) | 8'h03);
      if (p != 0) begin
        wr(b + s, 8'hF0);
        rd(b + s, 8'hF0);
        chk(padOe[p], 8'h5C);
        chk(padOut[p] & padOe[p], 8'h10 | (pat & 8'h0C));
        wr(b + s, 8'h00);
      end
      wr(b + OFF_DIR, 8'h00);
    end
    $display("test groups done");
    // Flag word of group zero is six bits wide
    wr(10'h013, 8'hFF);
    rd(10'h013, 8'hFC);
    wr(10'h013, 8'h00);
    foreach (bad[i]) begin
      xfer(1'b0, bad[i], 8'h00);
      chk(erv, 1'b1);
    end
    $display("test map done");
    // Each vector: masked event, then enabled, then cleared
    for (int v = 0; v < NIRQ; v++) begin
      m = 8'h01 << vBit[v];
      extLevel[vPort[v]][vPin[v]] <= v[0];
      repeat (4) @(posedge sys_clk);
      wr(PORT_BASE[vPort[v]] + OFF_IES, (8'h01 << vPin[v]) & {8{v[0]}});
      wr(vIfg[v], 8'h00);
      wr(vIe[v], 8'h00);
      extLevel[vPort[v]][vPin[v]] <= ~v[0];
      repeat (5) @(posedge sys_clk);
      chk(portIrq, 5'h00);
      rd(vIfg[v], m);
      wr(vIe[v], m);
      repeat (3) @(posedge sys_clk);
      chk(portIrq, 5'h01 << v);
      wr(vIfg[v], 8'h00);
      repeat (3) @(posedge sys_clk);
      chk(portIrq, 5'h00);
      rd(vIfg[v], 8'h00);
      wr(vIe[v], 8'h00);
    end
    $display("test vectors done");
    wrapUp();
  end
  // Watchdog against a hung bus
  initial begin
    repeat (20000) @(posedge sys_clk);
    errTotal++;
    $display("mismatch at %0t: watchdog expired", $time);
    wrapUp();
  end
endmodule
bind fpio_top fpio_top_asserts u_chk (.sys_clk(sys_clk), .arst_n(arst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .padIn(padIn),
  .padOe(padOe), .periphIn(periphIn));
`default_nettype wire
